/* cc_timer_pkg.sv */
// package: register map, field positions and constants of the capture/compare timer
`default_nettype none
package cc_timer_pkg;
  // register byte offsets on the bus
  localparam logic [15:0] OFF_UNIT_MODE = 16'hff30;
  localparam logic [15:0] OFF_COUNT_CTRL = 16'hff34;
  localparam logic [15:0] OFF_OUT_CTRL = 16'hff38;
  localparam logic [15:0] OFF_DIV_SEL = 16'hff3c;
  localparam logic [15:0] OFF_EDGE_SEL = 16'hff40;
  localparam logic [15:0] OFF_MAIN_COUNT = 16'hff44;
  localparam logic [15:0] OFF_CC_BASE = 16'hff48;
  localparam logic [15:0] OFF_EVENT_STATUS = 16'hff58;
  // unit mode register fields
  localparam int UM_SEL_LSB = 0;
  localparam int UM_MODE0_BIT = 4;
  localparam int UM_MODE2_BIT = 5;
  localparam int UM_T1_CLR_BIT = 6;
  localparam int UM_T1_MODE_BIT = 7;
  // count control register field
  localparam int CC_RUN_BIT = 0;
  // output control: per pin an enable and an active-level bit
  localparam int OC_EN_LSB = 0;
  localparam int OC_ALV_LSB = 4;
  // reset values, counter step and counter maximum
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // divider: five divisions, smallest is 4 (log2 = 2)
  localparam int DIV_CHOICES = 5;
  localparam int DIV_LOG2_MIN = 2;
  localparam logic [2:0] DIV_SEL_MAX = 3'h4;
  // edge select codes per input
  typedef enum logic [1:0] {edge_falling, edge_rising, edge_none, edge_both} edge_mode_t;
  // events raised by the timer, all one-cycle pulses
  typedef struct packed {
    logic overflow;
    logic [3:0] match;
    logic [3:0] ext_edge;
  } timer_events_t;
endpackage : cc_timer_pkg
`default_nettype wire

/* cc_timer.sv */
// capture/compare timer: prescaler, 16-bit counter, four capture/compare channels, output control
//
// How it works
// - sixteen-bit free-running up-counter advancing once per selected count tick.
// - prescaler divides pclk; selector picks one of five divisions.
// - counter advances only while the run bit is set.
// - counter readable as a whole word; writes to it are refused with pslverr.
// - reset clears counter to zero and leaves it stopped.
// - four 16-bit capture/compare registers, read/write, no reset value.
// - unit mode bits 3..0 select each channel; zero means capture.
// - compare equal to counter raises match pulse and output event.
// - capture channel copies counter on each valid input edge.
// - captured value held until that channel's next trigger.
// - no capture while the run bit is clear.
// - edge detector per input, edge chosen by edge select, gives request and trigger.
// - toggle mode inverts the pin on each match of its channel.
// - mode bit 0 toggle, 1 set/reset, pins 0 and 2 only.
// - disabled output drives fixed level chosen by output control.
// - unit mode register, 8-bit read/write at 0xff30, resets to zero.
// - bits 7 and 6 pass through to the second timer.
// - starting from stopped, first tick gives one; rewriting run keeps count.
// - clearing run zeroes counter at once and stops capture and match.
// - tick at maximum wraps to zero, raises overflow, keeps counting.
// - disabled pin is high when active-level bit is 0, low when 1.
`default_nettype none
module cc_timer
  import cc_timer_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ext_edge_inputs,
  output logic [3:0] timer_pins,
  output logic [3:0] match_irq_n,
  output logic [3:0] ext_edge_irq,
  output logic counter_overflow_irq,
  output logic second_timer_output_mode_bit,
  output logic second_timer_clear_control
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (CHANNELS != 4) begin : g_bad_channels
    $error("cc_timer supports exactly four channels");
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] unit_mode_register;
  logic [7:0] count_control_register;
  logic [7:0] output_control_register;
  logic [2:0] clock_divider_select_register;
  logic [7:0] edge_select_register;
  logic [15:0] main_counter;
  logic [15:0] capture_compare_n [CHANNELS];
  logic [3:0] pin_state;
  logic [3:0] prev_inputs;
  logic [6:0] prescale;
  logic [6:0] prev_prescale;
  timer_events_t sticky_events;
  timer_events_t now_events;

  logic count_run_bit;
  logic count_tick;
  logic wr_access;
  logic rd_setup;
  logic [3:0] valid_edge;
  logic [3:0] capture_hit;
  logic [3:0] match_hit;
  logic [3:0] next_pins;
  logic [31:0] next_rdata;
  logic addr_ok;

  // run bit, write access phase and read setup phase
  assign count_run_bit = count_control_register[CC_RUN_BIT];
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // decode a register offset to a channel index, 4 when it is not a channel
  function automatic logic [2:0] cc_index(input logic [15:0] addr);
    logic [15:0] rel;
    rel = addr - OFF_CC_BASE;
    if (addr >= OFF_CC_BASE && rel < 16'h0010 && rel[1:0] == 2'h0) begin
      cc_index = {1'b0, rel[3:2]};
    end else begin
      cc_index = 3'h4;
    end
  endfunction : cc_index

  // ---------------------------------------------------------------
  // prescaler and selector
  // ---------------------------------------------------------------
  // free divider, cleared while stopped so the first tick is a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
      prev_prescale <= '0;
    end else if (!count_run_bit) begin
      prescale <= '0;
      prev_prescale <= '0;
    end else begin
      prescale <= prescale + 7'h01;
      prev_prescale <= prescale;
    end
  end

  // tick when the selected divider bit falls: one pulse per 2^(sel+2) clocks
  always_comb begin
    logic [2:0] sel;
    int b;
    sel = (clock_divider_select_register > DIV_SEL_MAX) ? DIV_SEL_MAX : clock_divider_select_register;
    b = int'(sel) + DIV_LOG2_MIN - 1;
    count_tick = count_run_bit & prev_prescale[b] & ~prescale[b];
  end

  // ---------------------------------------------------------------
  // main counter
  // ---------------------------------------------------------------
  // counter: held at zero while stopped, one step per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_counter <= RST_COUNT;
    end else if (!count_run_bit) begin
      main_counter <= RST_COUNT;
    end else if (count_tick) begin
      main_counter <= main_counter + COUNT_ONE;
    end
  end

  // overflow pulse when the tick meets the maximum
  assign counter_overflow_irq = count_tick & (main_counter == COUNT_MAX);

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  // previous levels; reset to the idle low level so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_inputs <= '0;
    end else begin
      prev_inputs <= ext_edge_inputs;
    end
  end

  // valid edge per input by its two edge select bits
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_edge
      logic rise;
      logic fall;
      // raw edges against the level of the previous cycle
      assign rise = ext_edge_inputs[gi] & ~prev_inputs[gi];
      assign fall = ~ext_edge_inputs[gi] & prev_inputs[gi];
      always_comb begin
        case (edge_mode_t'(edge_select_register[2*gi +: 2]))
          edge_falling: valid_edge[gi] = fall;
          edge_rising: valid_edge[gi] = rise;
          edge_both: valid_edge[gi] = rise | fall;
          default: valid_edge[gi] = 1'b0;
        endcase
      end
      // capture only in capture mode while running
      assign capture_hit[gi] = valid_edge[gi] & ~unit_mode_register[UM_SEL_LSB + gi] & count_run_bit;
      // compare on each counter tick result, only while running
      assign match_hit[gi] = unit_mode_register[UM_SEL_LSB + gi] & count_run_bit & count_tick
                             & (capture_compare_n[gi] == main_counter + COUNT_ONE);
    end
  endgenerate

  // interrupt requests leave as one-cycle pulses
  assign ext_edge_irq = valid_edge;
  assign match_irq_n = match_hit;

  // ---------------------------------------------------------------
  // capture/compare registers
  // ---------------------------------------------------------------
  // no reset: contents are undefined until written or captured
  // capture is tested first so a trigger beats a software write on the same edge
  always_ff @(posedge pclk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (capture_hit[i]) begin
        capture_compare_n[i] <= main_counter;
      end else if (wr_access && cc_index(paddr) == 3'(i)) begin
        capture_compare_n[i] <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // control registers; upper bits of the bus word are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_mode_register <= RST_BYTE;
      count_control_register <= RST_BYTE;
      output_control_register <= RST_BYTE;
      clock_divider_select_register <= '0;
      edge_select_register <= RST_BYTE;
    end else if (wr_access) begin
      if (paddr == OFF_UNIT_MODE) begin
        unit_mode_register <= pwdata[7:0];
      end else if (paddr == OFF_COUNT_CTRL) begin
        count_control_register <= pwdata[7:0];
      end else if (paddr == OFF_OUT_CTRL) begin
        output_control_register <= pwdata[7:0];
      end else if (paddr == OFF_DIV_SEL) begin
        clock_divider_select_register <= pwdata[2:0];
      end else if (paddr == OFF_EDGE_SEL) begin
        edge_select_register <= pwdata[7:0];
      end
    end
  end

  // bits 7 and 6 only pass through to the second timer
  assign second_timer_output_mode_bit = unit_mode_register[UM_T1_MODE_BIT];
  assign second_timer_clear_control = unit_mode_register[UM_T1_CLR_BIT];

  // ---------------------------------------------------------------
  // event record
  // ---------------------------------------------------------------
  // events of this cycle gathered into one record
  assign now_events = '{overflow: counter_overflow_irq, match: match_hit, ext_edge: valid_edge};

  // sticky record; cleared in the status read's setup cycle, when its data is taken,
  // so an event of that same cycle wins and is kept for the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_events <= '0;
    end else begin
      if (rd_setup && paddr == OFF_EVENT_STATUS) begin
        sticky_events <= now_events;
      end else begin
        sticky_events <= sticky_events | now_events;
      end
    end
  end

  // ---------------------------------------------------------------
  // output control
  // ---------------------------------------------------------------
  // next pulse level: toggle on match, set/reset overrides pins 0 and 2
  always_comb begin
    next_pins = pin_state;
    for (int i = 0; i < CHANNELS; i++) begin
      if (match_hit[i]) begin
        next_pins[i] = ~pin_state[i];
      end
    end
    if (unit_mode_register[UM_MODE0_BIT]) begin
      next_pins[0] = match_hit[0] ? 1'b1 : (match_hit[1] ? 1'b0 : pin_state[0]);
    end
    if (unit_mode_register[UM_MODE2_BIT]) begin
      next_pins[2] = match_hit[2] ? 1'b1 : (match_hit[3] ? 1'b0 : pin_state[2]);
    end
  end

  // pulse level is kept when the timer stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_state <= '0;
    end else begin
      pin_state <= next_pins;
    end
  end

  // registered pins: pulse level when enabled, else fixed level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_pins <= 4'hf;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (output_control_register[OC_EN_LSB + i]) begin
          timer_pins[i] <= next_pins[i];
        end else begin
          timer_pins[i] <= ~output_control_register[OC_ALV_LSB + i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // bus read path
  // ---------------------------------------------------------------
  // read mux; a write to the counter is refused
  always_comb begin
    logic [2:0] ci;
    ci = cc_index(paddr);
    next_rdata = '0;
    addr_ok = 1'b1;
    if (paddr == OFF_UNIT_MODE) begin
      next_rdata[7:0] = unit_mode_register;
    end else if (paddr == OFF_COUNT_CTRL) begin
      next_rdata[7:0] = count_control_register;
    end else if (paddr == OFF_OUT_CTRL) begin
      next_rdata[7:0] = output_control_register;
    end else if (paddr == OFF_DIV_SEL) begin
      next_rdata[2:0] = clock_divider_select_register;
    end else if (paddr == OFF_EDGE_SEL) begin
      next_rdata[7:0] = edge_select_register;
    end else if (paddr == OFF_MAIN_COUNT) begin
      next_rdata[15:0] = main_counter;
      addr_ok = ~pwrite;
    end else if (paddr == OFF_EVENT_STATUS) begin
      next_rdata[8:0] = sticky_events;
    end else if (ci != 3'h4) begin
      next_rdata[15:0] = capture_compare_n[ci[1:0]];
    end else begin
      addr_ok = 1'b0;
    end
  end

  // read data taken in the setup cycle, stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end else begin
      prdata <= '0;
    end
  end

  // no wait states; refusal flagged in the access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

endmodule : cc_timer
`default_nettype wire

/* cc_timer_checker_assertions.sv */
// checker: port-level assertions for the capture/compare timer
`default_nettype none
module cc_timer_checker
  import cc_timer_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] ext_edge_inputs,
  input wire logic [3:0] timer_pins,
  input wire logic [3:0] match_irq_n,
  input wire logic [3:0] ext_edge_irq,
  input wire logic counter_overflow_irq,
  input wire logic second_timer_output_mode_bit,
  input wire logic second_timer_clear_control
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  // write access phase
  assign wr_acc = psel && penable && pwrite;
  sequence s_mode_write;
    wr_acc && paddr == OFF_UNIT_MODE;
  endsequence
  sequence s_inputs_still;
    $stable(ext_edge_inputs) [*4];
  endsequence
  a_ready_high: assert property (pready) else $error("ready low");
  a_idle_read_zero: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0) else $error("read data not zero");
  a_count_write_err: assert property (wr_acc && paddr == OFF_MAIN_COUNT |-> pslverr) else $error("counter write accepted");
  a_unmapped_err: assert property (psel && penable && paddr < OFF_UNIT_MODE |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_second_timer_bits: assert property (s_mode_write |=>
    {second_timer_output_mode_bit, second_timer_clear_control} == $past(pwdata[7:6])) else $error("t1 bits wrong");
  a_overflow_pulse: assert property (counter_overflow_irq |=> !counter_overflow_irq) else $error("overflow too long");
  a_match_pulse: assert property (|match_irq_n |=> match_irq_n == 4'h0) else $error("match too long");
  a_pin_cause: assert property (!$stable(timer_pins) |->
    $past(|match_irq_n) || $past(wr_acc) || $past(wr_acc, 2)) else $error("pin moved without cause");
  a_edge_quiet: assert property (s_inputs_still |-> ext_edge_irq == 4'h0) else $error("edge without input change");
endmodule : cc_timer_checker
bind cc_timer cc_timer_checker #(.CHANNELS(CHANNELS)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_edge_inputs(ext_edge_inputs), .timer_pins(timer_pins), .match_irq_n(match_irq_n),
  .ext_edge_irq(ext_edge_irq), .counter_overflow_irq(counter_overflow_irq),
  .second_timer_output_mode_bit(second_timer_output_mode_bit),
  .second_timer_clear_control(second_timer_clear_control));
`default_nettype wire

/* pulse_src.sv */
// partner model: external pulse sources feeding the edge inputs
`default_nettype none
module pulse_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] want,
  output logic [3:0] ext_level
);
  // levels change just after a rising edge and hold a whole cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_level <= 4'h0;
    end else begin
      ext_level <= want;
    end
  end
endmodule : pulse_src
`default_nettype wire

/* tb_top.sv */
// testbench: directed scenarios for the capture/compare timer
`default_nettype none
module tb_top
  import cc_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rerr, ovf, t1m, t1c;
  logic [3:0] want = 4'h0, ext_in, pins, mirq, eirq;
  logic [7:0] ev;
  int n_mismatch = 0, checked = 0;
  assign ev = {eirq, mirq};
  always #12.5 pclk = ~pclk;
  cc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_edge_inputs(ext_in),
    .timer_pins(pins), .match_irq_n(mirq), .ext_edge_irq(eirq), .counter_overflow_irq(ovf),
    .second_timer_output_mode_bit(t1m), .second_timer_clear_control(t1c));
  pulse_src src (.pclk(pclk), .presetn(presetn), .want(want), .ext_level(ext_in));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the rising edge that sees ready; data and error are taken there
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    rerr = pslverr;
    if (i == 50) begin
      n_mismatch++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // wait for an event bit; n is the cycle count until it shows
  task automatic wait_ev(input int b, output int n);
    for (n = 0; n < 3000; n++) begin
      @(negedge pclk);
      if (ev[b] === 1'b1) break;
      @(posedge pclk);
    end
    if (n == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask : wait_ev
  task automatic t_reset;
    apb(0, OFF_UNIT_MODE, 0);
    chk(rd, 0);
    apb(0, OFF_MAIN_COUNT, 0);
    chk(rd, 0);
    chk(32'(pins), 32'hf);
    apb(0, 16'h0010, 0);
    chk({rerr, rd[30:0]}, 32'h80000000);
    apb(1, OFF_UNIT_MODE, 32'hc0);
    chk(32'({t1m, t1c}), 32'h3);
    apb(0, OFF_UNIT_MODE, 0);
    chk(rd, 32'hc0);
    $display("done reset");
  endtask : t_reset
  task automatic t_count;
    int i;
    apb(1, OFF_DIV_SEL, 0);
    apb(1, OFF_COUNT_CTRL, 1);
    rd = 0;
    for (i = 0; i < 20 && rd == 0; i++) apb(0, OFF_MAIN_COUNT, 0);
    chk(rd, 1);
    apb(1, OFF_COUNT_CTRL, 1);
    apb(0, OFF_MAIN_COUNT, 0);
    chk(32'(rd > 1), 1);
    apb(1, OFF_MAIN_COUNT, 0);
    chk(32'(rerr), 1);
    apb(1, OFF_COUNT_CTRL, 0);
    apb(0, OFF_MAIN_COUNT, 0);
    chk(rd, 0);
    apb(0, OFF_MAIN_COUNT, 0);
    chk(rd, 0);
    $display("done count");
  endtask : t_count
  task automatic t_divider;
    int s, n;
    logic p;
    apb(1, OFF_UNIT_MODE, 32'h03);
    apb(1, OFF_CC_BASE, 1);
    apb(1, OFF_CC_BASE + 16'h4, 2);
    apb(1, OFF_OUT_CTRL, 32'h21);
    for (s = 0; s < DIV_CHOICES; s++) begin
      apb(1, OFF_COUNT_CTRL, 0);
      apb(1, OFF_DIV_SEL, 32'(s));
      apb(1, OFF_COUNT_CTRL, 1);
      p = pins[0];
      wait_ev(0, n);
      wait_ev(1, n);
      chk(32'(n + 1), 32'(1 << (s + 2)));
      chk(32'(pins[0]), 32'(!p));
    end
    chk(32'(pins[3:1]), 32'h6);
    $display("done divider");
  endtask : t_divider
  task automatic t_setreset;
    int n;
    apb(1, OFF_COUNT_CTRL, 0);
    apb(1, OFF_UNIT_MODE, 32'h13);
    apb(1, OFF_CC_BASE, 2);
    apb(1, OFF_CC_BASE + 16'h4, 1);
    apb(1, OFF_DIV_SEL, 0);
    apb(0, OFF_EVENT_STATUS, 0);
    chk(rd, 32'h30);
    apb(1, OFF_COUNT_CTRL, 1);
    wait_ev(1, n);
    @(negedge pclk);
    chk(32'(pins[0]), 0);
    wait_ev(0, n);
    @(negedge pclk);
    chk(32'(pins[0]), 1);
    @(posedge pclk);
    apb(0, OFF_EVENT_STATUS, 0);
    chk(rd, 32'h30);
    apb(0, OFF_EVENT_STATUS, 0);
    chk(rd, 0);
    $display("done set reset");
  endtask : t_setreset
  task automatic t_capture;
    int n;
    logic [31:0] a, c;
    apb(1, OFF_COUNT_CTRL, 0);
    apb(1, OFF_UNIT_MODE, 0);
    apb(1, OFF_EDGE_SEL, 32'h2d);
    apb(1, OFF_DIV_SEL, 4);
    apb(1, OFF_CC_BASE, 32'h1234);
    want <= 4'h1;
    wait_ev(4, n);
    apb(0, OFF_CC_BASE, 0);
    chk(rd, 32'h1234);
    want <= 4'h0;
    apb(1, OFF_COUNT_CTRL, 1);
    repeat (100) @(posedge pclk);
    apb(0, OFF_MAIN_COUNT, 0);
    a = rd;
    want <= 4'h1;
    wait_ev(4, n);
    apb(0, OFF_CC_BASE, 0);
    c = rd;
    apb(0, OFF_MAIN_COUNT, 0);
    chk(32'(c == a || c == rd), 1);
    want <= 4'h2;
    wait_ev(5, n);
    want <= 4'h0;
    wait_ev(5, n);
    apb(0, OFF_CC_BASE, 0);
    chk(rd, c);
    want <= 4'hc;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'(eirq), 32'h0);
    @(posedge pclk);
    want <= 4'h0;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'(eirq), 32'h8);
    @(posedge pclk);
    $display("done capture");
  endtask : t_capture
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_count();
    t_divider();
    t_setreset();
    t_capture();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
